/* File: cc_unit.sv */
// Capture/compare unit: the device end of the link
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cc_unit #(
  parameter int WIDTH = 16
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  cc_link.unit lnk, // Link to controller
  output logic periph_out, // Unit output for other peripherals
  output logic event_flag // Event flag copy
);

  if (WIDTH != 16) begin : g_width_bad
    $error("cc_unit serves a 16-bit timebase only");
  end

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  function automatic logic is_capture(input logic [3:0] m);
    logic r;
    r = 1'b0;
    if (m == `CC_FS_CAP_FALL) begin
      r = 1'b1;
    end else if (m == `CC_FS_CAP_RISE) begin
      r = 1'b1;
    end else if (m == `CC_FS_CAP_RISE4) begin
      r = 1'b1;
    end else if (m == `CC_FS_CAP_RISE16) begin
      r = 1'b1;
    end
    return r;
  endfunction

  function automatic logic is_compare(input logic [3:0] m);
    logic r;
    r = 1'b0;
    if (m == `CC_FS_CMP_TOGGLE) begin
      r = 1'b1;
    end else if (m == `CC_FS_CMP_SET) begin
      r = 1'b1;
    end else if (m == `CC_FS_CMP_CLEAR) begin
      r = 1'b1;
    end else if (m == `CC_FS_CMP_SWEVT) begin
      r = 1'b1;
    end else if (m == `CC_FS_CMP_CONV) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [3:0] mode_q;
  logic cap_mode;
  logic cmp_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `CC_FS_OFF;
    end else if (lnk.ctl_wr) begin
      mode_q <= lnk.ctl_wdata;
    end
  end

  assign cap_mode = is_capture(mode_q);
  assign cmp_mode = is_compare(mode_q);

  // ----------------------------------------------------------------
  // Capture source and edge detection
  // ----------------------------------------------------------------
  logic src_lvl;
  logic src_prev_q;
  logic rise;
  logic fall;

  // routed pin level is source zero
  assign src_lvl = lnk.src[lnk.cts];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
    end
  end

  assign rise = src_lvl & ~src_prev_q;
  assign fall = ~src_lvl & src_prev_q;

  // ----------------------------------------------------------------
  // Edge prescaler
  // ----------------------------------------------------------------
  logic [3:0] ps_q;
  logic cap_evt;

  // prescaler cleared when off or not capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_q <= 4'h0;
    end else if (!cap_mode) begin
      ps_q <= 4'h0;
    end else if (rise) begin
      if (mode_q == `CC_FS_CAP_RISE4 && ps_q >= `CC_PS_LAST4) begin
        ps_q <= 4'h0;
      end else begin
        ps_q <= ps_q + 4'h1;
      end
    end
  end

  always_comb begin
    cap_evt = 1'b0;
    if (mode_q == `CC_FS_CAP_FALL) begin
      cap_evt = fall;
    end else if (mode_q == `CC_FS_CAP_RISE) begin
      cap_evt = rise;
    end else if (mode_q == `CC_FS_CAP_RISE4) begin
      cap_evt = rise && (ps_q >= `CC_PS_LAST4);
    end else if (mode_q == `CC_FS_CAP_RISE16) begin
      cap_evt = rise && (ps_q == `CC_PS_LAST16);
    end
  end

  // ----------------------------------------------------------------
  // Value pair
  // ----------------------------------------------------------------
  cc_pkg::cc_word_t val_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= 16'h0000;
    end else if (cap_evt) begin
      val_q <= lnk.tmr_cnt;
    end else if (lnk.val_wr) begin
      val_q <= lnk.val_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  logic match;
  logic conv_pend_q;

  assign match = cmp_mode && lnk.tmr_upd && (val_q == lnk.tmr_cnt);

  // match action on the output latch
  // zero control write clears the latch
  logic out_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (lnk.ctl_wr && lnk.ctl_wdata == `CC_FS_OFF) begin
      out_q <= 1'b0;
    end else if (match) begin
      if (mode_q == `CC_FS_CMP_TOGGLE) begin
        out_q <= ~out_q;
      end else if (mode_q == `CC_FS_CMP_SET) begin
        out_q <= 1'b1;
      end else if (mode_q == `CC_FS_CMP_CLEAR) begin
        out_q <= 1'b0;
      end
    end
  end

  // every match may trigger the converter
  // only when this unit is selected
  logic conv_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= match && lnk.conv_sel;
    end
  end

  // trigger mode also resets the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_pend_q <= 1'b0;
    end else begin
      conv_pend_q <= match && (mode_q == `CC_FS_CMP_CONV);
    end
  end

  // reset dropped if match was removed
  logic rst_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= conv_pend_q && (val_q == lnk.tmr_cnt) && !lnk.val_wr;
    end
  end

  // ----------------------------------------------------------------
  // Event flag and wake
  // ----------------------------------------------------------------
  logic flag_q;
  logic wake_q;

  // a source write may set it too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (cap_evt || match) begin
      flag_q <= 1'b1;
    end else if (lnk.flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= lnk.sleep && lnk.irq_en && (cap_evt || match || flag_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic pout_q;
  logic eflag_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pout_q <= 1'b0;
      eflag_q <= 1'b0;
    end else begin
      pout_q <= out_q;
      eflag_q <= flag_q;
    end
  end

  assign periph_out = pout_q;
  assign event_flag = eflag_q;
  assign lnk.mode = mode_q;
  assign lnk.val = val_q;
  assign lnk.flag = flag_q;
  assign lnk.unit_out = out_q;
  assign lnk.conv_trig = conv_q;
  assign lnk.tmr_rst = rst_q;
  assign lnk.wake = wake_q;

endmodule
`default_nettype wire

/* File: cc_regs.svh */
// Constants for the capture/compare unit and its controller
`ifndef CC_REGS_SVH
`define CC_REGS_SVH

// ----------------------------------------------------------------
// Function-select codes
// ----------------------------------------------------------------
`define CC_FS_OFF 4'h0
`define CC_FS_CMP_TOGGLE 4'h2
`define CC_FS_CAP_FALL 4'h4
`define CC_FS_CAP_RISE 4'h5
`define CC_FS_CAP_RISE4 4'h6
`define CC_FS_CAP_RISE16 4'h7
`define CC_FS_CMP_SET 4'h8
`define CC_FS_CMP_CLEAR 4'h9
`define CC_FS_CMP_SWEVT 4'hA
`define CC_FS_CMP_CONV 4'hB

// ----------------------------------------------------------------
// Prescaler terminal counts
// ----------------------------------------------------------------
`define CC_PS_LAST4 4'h3
`define CC_PS_LAST16 4'hF

// ----------------------------------------------------------------
// Controller register offsets
// ----------------------------------------------------------------
`define CC_OFF_CTRL 12'h000
`define CC_OFF_SRC 12'h004
`define CC_OFF_VALUE 12'h008
`define CC_OFF_STATUS 12'h00C
`define CC_OFF_TCOUNT 12'h010
`define CC_OFF_TCTRL 12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CC_SRC_CONV_SEL 8
`define CC_SRC_IRQ_EN 9
`define CC_SRC_SLEEP 10
`define CC_SRC_DIR 11
`define CC_SRC_ROUTE 12
`define CC_SRC_LATCH 13
`define CC_SRC_LVL_LO 16
`define CC_SRC_LVL_HI 22
`define CC_ST_FLAG 0
`define CC_ST_OUT 1
`define CC_ST_WAKE 2
`define CC_TC_RUN 0
`define CC_TC_EXT 1
`define CC_TC_DIV_LO 8
`define CC_TC_DIV_HI 15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CC_RST_SRC 32'h0000_0800
`define CC_RST_TCTRL 32'h0000_0000

`endif

/* File: cc_pkg.sv */
// Types shared by both ends of the capture/compare unit
`include "cc_regs.svh"
package cc_pkg;
  typedef enum logic [3:0] {
    CC_OFF = `CC_FS_OFF,
    CC_CMP_TOGGLE = `CC_FS_CMP_TOGGLE,
    CC_CAP_FALL = `CC_FS_CAP_FALL,
    CC_CAP_RISE = `CC_FS_CAP_RISE,
    CC_CAP_RISE4 = `CC_FS_CAP_RISE4,
    CC_CAP_RISE16 = `CC_FS_CAP_RISE16,
    CC_CMP_SET = `CC_FS_CMP_SET,
    CC_CMP_CLEAR = `CC_FS_CMP_CLEAR,
    CC_CMP_SWEVT = `CC_FS_CMP_SWEVT,
    CC_CMP_CONV = `CC_FS_CMP_CONV
  } cc_mode_e;
  typedef logic [15:0] cc_word_t;
endpackage

/* File: cc_link.sv */
// Link between the capture/compare unit and its controller
`timescale 1ns/1ps
`default_nettype none
interface cc_link;
  logic ctl_wr;
  logic [3:0] ctl_wdata;
  logic [2:0] cts;
  logic val_wr;
  cc_pkg::cc_word_t val_wdata;
  logic flag_clr;
  logic irq_en;
  logic sleep;
  logic conv_sel;
  cc_pkg::cc_word_t tmr_cnt;
  logic tmr_upd;
  logic [7:0] src;
  logic [3:0] mode;
  cc_pkg::cc_word_t val;
  logic flag;
  logic unit_out;
  logic conv_trig;
  logic tmr_rst;
  logic wake;
  modport unit (
    input ctl_wr, ctl_wdata, cts, val_wr, val_wdata, flag_clr, irq_en,
    input sleep, conv_sel, tmr_cnt, tmr_upd, src,
    output mode, val, flag, unit_out, conv_trig, tmr_rst, wake
  );
  modport ctrl (
    output ctl_wr, ctl_wdata, cts, val_wr, val_wdata, flag_clr, irq_en,
    output sleep, conv_sel, tmr_cnt, tmr_upd, src,
    input mode, val, flag, unit_out, conv_trig, tmr_rst, wake
  );
endinterface
`default_nettype wire

/* File: cc_ctrl.sv */
// Controller end: APB registers, timebase, pin and sources
`timescale 1ns/1ps
`default_nettype none
module cc_ctrl (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic pin_i, // Pin level from outside
  output logic pin_o, // Pin drive level
  output logic pin_oe, // Pin drive enable
  output logic conv_start, // Converter start pulse
  cc_link.ctrl lnk // Link to unit
);

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic setup;
  logic wr_acc;
  logic hit;
  logic [31:0] rd_d;
  logic [31:0] src_q;
  logic [31:0] tctl_q;
  cc_pkg::cc_word_t cnt_q;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;

  always_comb begin
    hit = 1'b1;
    rd_d = 32'h0000_0000;
    if (paddr == `CC_OFF_CTRL) begin
      rd_d[3:0] = lnk.mode;
    end else if (paddr == `CC_OFF_SRC) begin
      rd_d = src_q;
    end else if (paddr == `CC_OFF_VALUE) begin
      rd_d[15:0] = lnk.val;
    end else if (paddr == `CC_OFF_STATUS) begin
      rd_d[`CC_ST_FLAG] = lnk.flag;
      rd_d[`CC_ST_OUT] = lnk.unit_out;
      rd_d[`CC_ST_WAKE] = lnk.wake;
    end else if (paddr == `CC_OFF_TCOUNT) begin
      rd_d[15:0] = cnt_q;
    end else if (paddr == `CC_OFF_TCTRL) begin
      rd_d = tctl_q;
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      prdata <= setup ? rd_d : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Registers and strobes toward the unit
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= `CC_RST_SRC;
      tctl_q <= `CC_RST_TCTRL;
    end else if (wr_acc && paddr == `CC_OFF_SRC) begin
      src_q <= pwdata;
    end else if (wr_acc && paddr == `CC_OFF_TCTRL) begin
      tctl_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.ctl_wr <= 1'b0;
      lnk.ctl_wdata <= `CC_FS_OFF;
      lnk.val_wr <= 1'b0;
      lnk.val_wdata <= 16'h0000;
      lnk.flag_clr <= 1'b0;
    end else begin
      lnk.ctl_wr <= wr_acc && paddr == `CC_OFF_CTRL;
      lnk.ctl_wdata <= pwdata[3:0];
      lnk.val_wr <= wr_acc && paddr == `CC_OFF_VALUE;
      lnk.val_wdata <= pwdata[15:0];
      lnk.flag_clr <= wr_acc && paddr == `CC_OFF_STATUS &&
                      pwdata[`CC_ST_FLAG];
    end
  end

  assign lnk.cts = src_q[2:0];
  assign lnk.conv_sel = src_q[`CC_SRC_CONV_SEL];
  assign lnk.irq_en = src_q[`CC_SRC_IRQ_EN];
  assign lnk.sleep = src_q[`CC_SRC_SLEEP];

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic tick;
  logic upd_q;
  logic halt;

  // timer steps on a divided enable only
  assign halt = src_q[`CC_SRC_SLEEP] && !tctl_q[`CC_TC_EXT];
  assign tick = tctl_q[`CC_TC_RUN] && !halt &&
                (div_q == tctl_q[`CC_TC_DIV_HI:`CC_TC_DIV_LO]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (tick || !tctl_q[`CC_TC_RUN]) begin
      div_q <= 8'h00;
    end else if (!halt) begin
      div_q <= div_q + 8'h01;
    end
  end

  // count changes only in step with pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      upd_q <= 1'b0;
    end else if (lnk.tmr_rst) begin
      cnt_q <= 16'h0000;
      upd_q <= 1'b1;
    end else if (wr_acc && paddr == `CC_OFF_TCOUNT) begin
      cnt_q <= pwdata[15:0];
      upd_q <= 1'b0;
    end else begin
      cnt_q <= tick ? cnt_q + 16'h0001 : cnt_q;
      upd_q <= tick;
    end
  end

  assign lnk.tmr_cnt = cnt_q;
  assign lnk.tmr_upd = upd_q;

  // ----------------------------------------------------------------
  // Pin and sources
  // ----------------------------------------------------------------
  logic pin_lvl;
  logic pin_o_q;
  logic pin_oe_q;
  logic conv_q;

  // direction bit low makes the pin an output
  assign pin_lvl = src_q[`CC_SRC_DIR] ? pin_i : pin_o_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      conv_q <= 1'b0;
    end else begin
      pin_o_q <= src_q[`CC_SRC_ROUTE] ? lnk.unit_out :
                 src_q[`CC_SRC_LATCH];
      pin_oe_q <= !src_q[`CC_SRC_DIR];
      conv_q <= lnk.conv_trig;
    end
  end

  assign lnk.src = {src_q[`CC_SRC_LVL_HI:`CC_SRC_LVL_LO], pin_lvl};
  assign pin_o = pin_o_q;
  assign pin_oe = pin_oe_q;
  assign conv_start = conv_q;

endmodule
`default_nettype wire

/* File: cc_properties.sv */
// Assertions on the link between the unit and its controller
`timescale 1ns/1ps
`default_nettype none
module cc_properties (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic ctl_wr, // Mode write
  input wire logic [3:0] ctl_wdata, // Mode data
  input wire logic [2:0] cts, // Source select
  input wire logic flag_clr, // Flag clear
  input wire logic irq_en, // Event enable
  input wire logic sleep, // Sleep
  input wire logic conv_sel, // Converter select
  input wire cc_pkg::cc_word_t tmr_cnt, // Timer count
  input wire logic tmr_upd, // Timer update
  input wire logic [7:0] src, // Sources
  input wire logic [3:0] mode, // Mode
  input wire cc_pkg::cc_word_t val, // Value pair
  input wire logic flag, // Event flag
  input wire logic unit_out, // Output latch
  input wire logic conv_trig, // Converter trigger
  input wire logic tmr_rst, // Timer reset
  input wire logic wake // Wake
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Event sequences
  // ------------------------------------------------------------
  sequence s_steady;
    $stable(cts) && $stable(mode);
  endsequence
  sequence s_match;
    mode inside {4'h2, [4'h8:4'hB]} && tmr_upd && val == tmr_cnt;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  cap_rise_a: assert property (
    mode == 4'h5 && $rose(src[cts]) ##0 s_steady
    |=> val == $past(tmr_cnt) && flag) else $error("rise capture missed");
  cap_fall_a: assert property (
    mode == 4'h4 && $fell(src[cts]) ##0 s_steady
    |=> val == $past(tmr_cnt) && flag) else $error("fall capture missed");
  flag_sticky_a: assert property (
    $fell(flag) |-> $past(flag_clr)) else $error("flag cleared by hardware");
  match_flag_a: assert property (
    s_match |=> flag) else $error("match left flag clear");
  cmp_set_a: assert property (
    mode == 4'h8 ##0 s_match |=> unit_out) else $error("set missed");
  cmp_clear_a: assert property (
    mode == 4'h9 ##0 s_match |=> !unit_out) else $error("clear missed");
  cmp_toggle_a: assert property (
    mode == 4'h2 && !ctl_wr ##0 s_match |=> unit_out != $past(unit_out))
    else $error("toggle missed");
  zero_ctrl_a: assert property (
    ctl_wr && ctl_wdata == 4'h0 && !tmr_upd |=> !unit_out)
    else $error("output latch not cleared");
  conv_trig_a: assert property (
    conv_sel ##0 s_match |-> ##[1:2] conv_trig) else $error("no trigger");
  conv_only_a: assert property (
    conv_trig |-> $past(conv_sel)) else $error("trigger while unselected");
  tmr_reset_a: assert property (
    tmr_rst |-> mode == 4'hB) else $error("timer reset in wrong mode");
  wake_gate_a: assert property (
    wake |-> $past(sleep && irq_en)) else $error("wake without enable");
endmodule
`default_nettype wire

/* File: capture_compare_unit_bench.sv */
// Bench joining the unit and its controller over the link
`timescale 1ns/1ps
`default_nettype none
`include "cc_regs.svh"
module capture_compare_unit_bench;
  logic pclk, presetn, psel, penable, pwrite, pin_i, slverr;
  logic pready, pslverr, pin_o, pin_oe, conv_start, periph_out, event_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, m;
  int checked = 0;
  int miscompares = 0;
  int convs = 0;
  cc_pkg::cc_mode_e cmp_m [4] = '{cc_pkg::CC_CMP_SET, cc_pkg::CC_CMP_CLEAR,
    cc_pkg::CC_CMP_TOGGLE, cc_pkg::CC_CMP_SWEVT};
  logic [31:0] cmp_o [4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0001,
    32'h0000_0001};
  cc_link lnk ();
  cc_unit i_cc_unit (.pclk, .presetn, .lnk(lnk), .periph_out, .event_flag);
  cc_ctrl i_cc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe,
    .conv_start, .lnk(lnk));
  cc_properties i_cc_properties (.pclk, .presetn, .ctl_wr(lnk.ctl_wr),
    .ctl_wdata(lnk.ctl_wdata), .cts(lnk.cts), .flag_clr(lnk.flag_clr),
    .irq_en(lnk.irq_en), .sleep(lnk.sleep), .conv_sel(lnk.conv_sel),
    .tmr_cnt(lnk.tmr_cnt), .tmr_upd(lnk.tmr_upd), .src(lnk.src),
    .mode(lnk.mode), .val(lnk.val), .flag(lnk.flag),
    .unit_out(lnk.unit_out), .conv_trig(lnk.conv_trig),
    .tmr_rst(lnk.tmr_rst), .wake(lnk.wake));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (conv_start === 1'b1) begin
      convs++;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One APB transfer; read data and error land in q and slverr
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask
  task automatic settle;
    repeat (4) @(posedge pclk);
  endtask
  task automatic pulse(input logic lvl);
    pin_i <= lvl;
    settle();
  endtask
  task automatic wait_flag;
    int n;
    n = 0;
    while (event_flag !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    check(32'(event_flag), 32'h0000_0001);
  endtask
  initial begin
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pin_i = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      rd(12'(i * 4), i == 1 ? `CC_RST_SRC : 32'h0000_0000);
    end
    rd(12'h018, 32'h0000_0000);
    check(32'(slverr), 32'h0000_0001);
    // ------------------------------------------------------------
    // Capture edges, overwrite and flag
    // ------------------------------------------------------------
    wr(`CC_OFF_TCOUNT, 32'h0000_1234);
    wr(`CC_OFF_CTRL, 32'(cc_pkg::CC_CAP_RISE));
    pulse(1'b1);
    wr(`CC_OFF_TCOUNT, 32'h0000_5678);
    pulse(1'b0);
    rd(`CC_OFF_VALUE, 32'h0000_1234);
    wr(`CC_OFF_TCOUNT, 32'h0000_9ABC);
    pulse(1'b1);
    wr(`CC_OFF_TCOUNT, 32'h0000_0DEF);
    pulse(1'b0);
    pulse(1'b1);
    rd(`CC_OFF_VALUE, 32'h0000_0DEF);
    rd(`CC_OFF_STATUS, 32'h0000_0001);
    wr(`CC_OFF_STATUS, 32'h0000_0001);
    rd(`CC_OFF_STATUS, 32'h0000_0000);
    wr(`CC_OFF_CTRL, 32'(cc_pkg::CC_CAP_FALL));
    wr(`CC_OFF_TCOUNT, 32'h0000_0ABC);
    pulse(1'b0);
    rd(`CC_OFF_VALUE, 32'h0000_0ABC);
    // Prescaler: a partial count is lost when the unit is turned off
    for (int k = 0; k < 2; k++) begin
      n = k ? 16 : 4;
      m = k ? 32'(cc_pkg::CC_CAP_RISE16) : 32'(cc_pkg::CC_CAP_RISE4);
      wr(`CC_OFF_CTRL, 32'h0000_0000);
      wr(`CC_OFF_VALUE, 32'h0000_0000);
      wr(`CC_OFF_CTRL, m);
      pulse(1'b1);
      pulse(1'b0);
      wr(`CC_OFF_CTRL, 32'h0000_0000);
      wr(`CC_OFF_CTRL, m);
      for (int i = 1; i <= n; i++) begin
        rd(`CC_OFF_VALUE, 32'h0000_0000);
        wr(`CC_OFF_TCOUNT, 32'(i));
        pulse(1'b1);
        pulse(1'b0);
      end
      rd(`CC_OFF_VALUE, 32'(n));
    end
    // ------------------------------------------------------------
    // Sources and port-write capture
    // ------------------------------------------------------------
    wr(`CC_OFF_CTRL, 32'(cc_pkg::CC_CAP_RISE));
    for (int s = 1; s < 8; s++) begin
      wr(`CC_OFF_SRC, `CC_RST_SRC | 32'(s));
      wr(`CC_OFF_TCOUNT, 32'(s * 273));
      wr(`CC_OFF_SRC, `CC_RST_SRC | 32'(s) | (32'h0000_8000 << s));
      settle();
      rd(`CC_OFF_VALUE, 32'(s * 273));
    end
    wr(`CC_OFF_SRC, 32'h0000_0000);
    wr(`CC_OFF_TCOUNT, 32'h0000_0F0F);
    wr(`CC_OFF_SRC, 32'h0000_2000);
    settle();
    check(32'({pin_oe, pin_o}), 32'h0000_0003);
    rd(`CC_OFF_VALUE, 32'h0000_0F0F);
    // ------------------------------------------------------------
    // Compare actions, zero control, converter, wake
    // ------------------------------------------------------------
    // pin made an output
    wr(`CC_OFF_SRC, 32'h0000_3000);
    wr(`CC_OFF_VALUE, 32'h0000_0010);
    for (int k = 0; k < 4; k++) begin
      wr(`CC_OFF_STATUS, 32'h0000_0001);
      wr(`CC_OFF_TCOUNT, 32'h0000_0000);
      wr(`CC_OFF_CTRL, 32'(cmp_m[k]));
      wr(`CC_OFF_TCTRL, 32'h0000_0301);
      wait_flag();
      wr(`CC_OFF_TCTRL, 32'h0000_0000);
      settle();
      rd(`CC_OFF_STATUS, 32'h0000_0001 | (cmp_o[k] << 1));
      check(32'({pin_o, periph_out}), cmp_o[k] * 3);
    end
    wr(`CC_OFF_CTRL, 32'h0000_0000);
    settle();
    rd(`CC_OFF_STATUS, 32'h0000_0001);
    check(32'({pin_oe, pin_o}), 32'h0000_0002);
    rd(`CC_OFF_SRC, 32'h0000_3000);
    for (int c = 0; c < 2; c++) begin
      wr(`CC_OFF_STATUS, 32'h0000_0001);
      wr(`CC_OFF_TCOUNT, 32'h0000_0000);
      wr(`CC_OFF_SRC, 32'h0000_1000 | 32'(c << 8));
      wr(`CC_OFF_CTRL, 32'(cc_pkg::CC_CMP_CONV));
      wr(`CC_OFF_TCTRL, 32'h0000_0301);
      wait_flag();
      repeat (10) settle();
      wr(`CC_OFF_TCTRL, 32'h0000_0000);
      apb(1'b0, `CC_OFF_TCOUNT, 32'h0000_0000);
      check(32'(q <= 32'h0000_0014), 32'h0000_0001);
      check(32'(convs > 0), 32'(c));
    end
    wr(`CC_OFF_CTRL, 32'h0000_0000);
    wr(`CC_OFF_SRC, 32'h0000_0E00);
    settle();
    rd(`CC_OFF_STATUS, 32'h0000_0005);
    wr(`CC_OFF_SRC, 32'h0000_0C00);
    settle();
    rd(`CC_OFF_STATUS, 32'h0000_0001);
    // Mid-run reset returns source, status, value and control to their reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CC_OFF_SRC, `CC_RST_SRC);
    rd(`CC_OFF_STATUS, 32'h0000_0000);
    rd(`CC_OFF_VALUE, 32'h0000_0000);
    rd(`CC_OFF_CTRL, 32'h0000_0000);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
